// >>> src/dqt_pkg.sv
// dqt_pkg: constants, types and latency lookup for the data-bus termination control
// assumes: latencies are counted in link clock cycles (nCK), sampled by a faster core clock
package dqt_pkg;

   localparam int unsigned SYNC_STAGES = 2;
   localparam int unsigned LAT_W       = 6;
   localparam int unsigned SET_W       = 3;

   // termination setting field
   localparam logic [SET_W-1:0] TERM_DISABLED = 3'h0;
   localparam logic [SET_W-1:0] TERM_MIN_CODE = 3'h1;
   localparam logic [SET_W-1:0] TERM_MAX_CODE = 3'h6;

   // extra turn-off latency for burst length 32
   localparam logic [LAT_W-1:0] BL32_OFF_EXTRA = 6'h08;
   localparam logic [LAT_W-1:0] LAT_ZERO       = 6'h00;
   localparam logic [LAT_W-1:0] LAT_ONE        = 6'h01;

   // turn-on / turn-off latencies in nCK, preamble of two cycles, burst length 16
   localparam logic [LAT_W-1:0] ON_B_533   = 6'h06;
   localparam logic [LAT_W-1:0] OFF_B_533  = 6'h16;
   localparam logic [LAT_W-1:0] ON_A_800   = 6'h04;
   localparam logic [LAT_W-1:0] ON_B_800   = 6'h0c;
   localparam logic [LAT_W-1:0] OFF_A_800  = 6'h14;
   localparam logic [LAT_W-1:0] OFF_B_800  = 6'h1c;
   localparam logic [LAT_W-1:0] ON_A_1066  = 6'h04;
   localparam logic [LAT_W-1:0] ON_B_1066  = 6'h0e;
   localparam logic [LAT_W-1:0] OFF_A_1066 = 6'h16;
   localparam logic [LAT_W-1:0] OFF_B_1066 = 6'h20;
   localparam logic [LAT_W-1:0] ON_A_1333  = 6'h06;
   localparam logic [LAT_W-1:0] ON_B_1333  = 6'h12;
   localparam logic [LAT_W-1:0] OFF_A_1333 = 6'h18;
   localparam logic [LAT_W-1:0] OFF_B_1333 = 6'h24;
   localparam logic [LAT_W-1:0] ON_A_1600  = 6'h06;
   localparam logic [LAT_W-1:0] ON_B_1600  = 6'h14;
   localparam logic [LAT_W-1:0] OFF_A_1600 = 6'h1a;
   localparam logic [LAT_W-1:0] OFF_B_1600 = 6'h28;
   localparam logic [LAT_W-1:0] ON_A_1866  = 6'h08;
   localparam logic [LAT_W-1:0] ON_B_1866  = 6'h18;
   localparam logic [LAT_W-1:0] OFF_A_1866 = 6'h1c;
   localparam logic [LAT_W-1:0] OFF_B_1866 = 6'h2c;

   typedef enum logic [2:0] {
      BIN_10_266,
      BIN_266_533,
      BIN_533_800,
      BIN_800_1066,
      BIN_1066_1333,
      BIN_1333_1600,
      BIN_1600_1866,
      BIN_1866_2133
   } dqt_bin_t;

   typedef struct packed {
      logic             valid;
      logic [LAT_W-1:0] on_lat;
      logic [LAT_W-1:0] off_lat;
   } dqt_lat_t;

   // latency pair for a frequency bin and write-latency set
   function automatic dqt_lat_t dqt_lookup(input dqt_bin_t bin, input logic set_b);
      dqt_lat_t r;
      r = '{valid: 1'b0, on_lat: LAT_ZERO, off_lat: LAT_ZERO};
      case (bin)
         BIN_533_800: begin
            if (set_b) begin
               r = '{valid: 1'b1, on_lat: ON_B_533, off_lat: OFF_B_533};
            end
         end
         BIN_800_1066: begin
            r = set_b ? dqt_lat_t'{1'b1, ON_B_800, OFF_B_800}
                      : dqt_lat_t'{1'b1, ON_A_800, OFF_A_800};
         end
         BIN_1066_1333: begin
            r = set_b ? dqt_lat_t'{1'b1, ON_B_1066, OFF_B_1066}
                      : dqt_lat_t'{1'b1, ON_A_1066, OFF_A_1066};
         end
         BIN_1333_1600: begin
            r = set_b ? dqt_lat_t'{1'b1, ON_B_1333, OFF_B_1333}
                      : dqt_lat_t'{1'b1, ON_A_1333, OFF_A_1333};
         end
         BIN_1600_1866: begin
            r = set_b ? dqt_lat_t'{1'b1, ON_B_1600, OFF_B_1600}
                      : dqt_lat_t'{1'b1, ON_A_1600, OFF_A_1600};
         end
         BIN_1866_2133: begin
            r = set_b ? dqt_lat_t'{1'b1, ON_B_1866, OFF_B_1866}
                      : dqt_lat_t'{1'b1, ON_A_1866, OFF_A_1866};
         end
         default: begin
            r = '{valid: 1'b0, on_lat: LAT_ZERO, off_lat: LAT_ZERO};
         end
      endcase
      return r;
   endfunction : dqt_lookup

endpackage : dqt_pkg

// >>> src/dqt_tmr_if.sv
// dqt_tmr_if: start, load and tick of one latency timer, and its expiry pulse
// assumes: all signals live on the core clock
`timescale 1ns/1ps
`default_nettype none
interface dqt_tmr_if;
   import dqt_pkg::*;
   logic             start;
   logic             tick;
   logic [LAT_W-1:0] load;
   logic             done;
   modport ctl (output start, output tick, output load, input done);
   modport tmr (input start, input tick, input load, output done);
endinterface : dqt_tmr_if
`default_nettype wire

// >>> src/dqt_sync.sv
// dqt_sync: two-flop synchroniser for a group of asynchronous inputs
// assumes: each bit is an independent level; first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module dqt_sync
   import dqt_pkg::*;
#(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } dqt_sync_st_t;

   dqt_sync_st_t s_q;
   dqt_sync_st_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.meta = din;
      s_d.stab = s_q.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.stab;
endmodule : dqt_sync
`default_nettype wire

// >>> src/dqt_lat_timer.sv
// dqt_lat_timer: counts link clock edges from a load and pulses when the count expires
// assumes: tick is a one-cycle pulse per link clock rising edge; start wins over tick
`timescale 1ns/1ps
`default_nettype none
module dqt_lat_timer
   import dqt_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   dqt_tmr_if.tmr    t
);
   typedef struct packed {
      logic [LAT_W-1:0] cnt;
      logic             done;
   } dqt_tmr_st_t;

   dqt_tmr_st_t s_q;
   dqt_tmr_st_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (t.start) begin
         // a later write restarts the count
         s_d.cnt = t.load;
      end else if (t.tick && (s_q.cnt != LAT_ZERO)) begin
         s_d.cnt = s_q.cnt - LAT_ONE;
         if (s_q.cnt == LAT_ONE) begin
            s_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign t.done = s_q.done;
endmodule : dqt_lat_timer
`default_nettype wire

// >>> src/dqt_term_ctrl.sv
// dqt_term_ctrl: automatic termination control of data, strobe and mask lines
// assumes: command pins and link clock are asynchronous and synchronised here;
// mode bits come from logic on clk and are used directly
//////////////////////////////////////////////////////////////////////////////////////////
// Operation
// - setting one to six: idle High-Z; write-type commands turn termination on
// - termination returns off after the write burst with no further command
// - turn-on latency counted in link cycles from CAS-2, fixed per speed bin
// - turn-off latency counted in link cycles from CAS-2, fixed per speed bin
// - turn-on and turn-off windows begin only after their latencies elapse
// - latencies per frequency bin and write-latency set from the fixed table
// - burst length 32 adds eight cycles to the turn-off latency
// - power-down keeps all termination disabled regardless of anything else
// - self refresh: termination off while CKE low, on while CKE high if enabled
// - write leveling with setting one to six keeps strobes terminated; zero or seven keeps off
// - write leveling keeps data and mask termination off unless self refresh is also set
// - zero setting disables; codes one to six select strengths 240 down to 40 ohm
// - each data, strobe and mask line switches individually, no control pin; here all switch together from one enable, except strobes in write leveling
//////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module dqt_term_ctrl
   import dqt_pkg::*;
#(
   parameter int unsigned DQ_W  = 16,
   parameter int unsigned DM_W  = 2,
   parameter int unsigned DQS_W = 2
) (
   input  wire logic              clk,
   input  wire logic              rst,
   // pins, asynchronous to clk
   input  wire logic              link_ck,
   input  wire logic              cke,
   input  wire logic              cmd_write1,
   input  wire logic              cmd_mask_write1,
   input  wire logic              cmd_mpc_wr_fifo,
   input  wire logic              cmd_cas2,
   input  wire logic              cmd_bl32,
   // mode bits, on clk
   input  wire logic [SET_W-1:0]  term_setting,
   input  wire dqt_bin_t          freq_bin,
   input  wire logic              write_latency_set_b,
   input  wire logic              wr_preamble_2ck,
   input  wire logic              power_down,
   input  wire logic              self_refresh,
   input  wire logic              write_leveling,
   // termination switches and status
   output var  logic [DQ_W-1:0]   dq_term_en,
   output var  logic [DM_W-1:0]   dm_term_en,
   output var  logic [DQS_W-1:0]  dqs_term_en,
   output var  logic [SET_W-1:0]  termination_strength,
   output var  logic              term_on_window,
   output var  logic              term_off_window,
   output var  logic [LAT_W-1:0]  term_on_latency,
   output var  logic [LAT_W-1:0]  term_off_latency,
   output var  logic              lat_undefined
);

   //////////////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   localparam int unsigned PIN_W = 7;

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_s;
   logic             ck_s;
   logic             cke_s;
   logic             wr1_s;
   logic             mwr1_s;
   logic             wfifo_s;
   logic             cas2_s;
   logic             bl32_s;

   assign pin_raw = {link_ck, cke, cmd_write1, cmd_mask_write1,
                     cmd_mpc_wr_fifo, cmd_cas2, cmd_bl32};

   dqt_sync #(
      .W (PIN_W)
   ) u_sync (
      .clk  (clk),
      .rst  (rst),
      .din  (pin_raw),
      .dout (pin_s)
   );

   assign {ck_s, cke_s, wr1_s, mwr1_s, wfifo_s, cas2_s, bl32_s} = pin_s;

   //////////////////////////////////////////////////////////////////////////////////////
   // latency timers
   dqt_tmr_if on_t ();
   dqt_tmr_if off_t ();

   dqt_lat_timer u_on_tmr (
      .clk (clk),
      .rst (rst),
      .t   (on_t)
   );

   dqt_lat_timer u_off_tmr (
      .clk (clk),
      .rst (rst),
      .t   (off_t)
   );

   //////////////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic              ck_prev;
      logic              armed;
      logic              armed_bl32;
      logic              active;
      logic [DQ_W-1:0]   dq_en;
      logic [DM_W-1:0]   dm_en;
      logic [DQS_W-1:0]  dqs_en;
      logic [SET_W-1:0]  strength;
      logic              on_win;
      logic              off_win;
      logic [LAT_W-1:0]  on_lat;
      logic [LAT_W-1:0]  off_lat;
      logic              lat_undef;
   } dqt_st_t;

   dqt_st_t s_q;
   dqt_st_t s_d;

   logic     ck_rise;
   logic     wr_cmd;
   logic     set_legal;
   logic     gated_off;
   logic     fire;
   dqt_lat_t lat;
   logic [LAT_W-1:0] off_load;

   // codes 1..6 select a strength, zero and the spare code disable
   assign set_legal = (term_setting >= TERM_MIN_CODE) && (term_setting <= TERM_MAX_CODE);

   assign ck_rise = ck_s && !s_q.ck_prev;
   assign wr_cmd  = wr1_s || mwr1_s || wfifo_s;
   assign lat     = dqt_lookup(freq_bin, write_latency_set_b);
   assign off_load = s_q.armed_bl32 ? (lat.off_lat + BL32_OFF_EXTRA) : lat.off_lat;

   // modes in which the write-driven path never switches on
   assign gated_off = power_down || self_refresh || write_leveling;

   // CAS-2 on the link edge right after a write-type command starts both latencies
   assign fire = ck_rise && s_q.armed && cas2_s && set_legal && lat.valid
                 && wr_preamble_2ck && !gated_off;

   assign on_t.start  = fire;
   assign on_t.tick   = ck_rise;
   assign on_t.load   = lat.on_lat;
   assign off_t.start = fire;
   assign off_t.tick  = ck_rise;
   assign off_t.load  = off_load;

   //////////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_d           = s_q;
      s_d.ck_prev   = ck_s;
      s_d.on_win    = 1'b0;
      s_d.off_win   = 1'b0;
      s_d.on_lat    = lat.on_lat;
      s_d.off_lat   = off_load;

      // command capture on each link clock rising edge
      if (ck_rise) begin
         if (wr_cmd) begin
            s_d.armed      = 1'b1;
            s_d.armed_bl32 = bl32_s;
         end else begin
            s_d.armed = 1'b0;
         end
         if (s_q.armed && cas2_s && set_legal && (!lat.valid || !wr_preamble_2ck)) begin
            s_d.lat_undef = 1'b1;
         end
      end

      // windows open only when the counted latency has elapsed
      if (off_t.done) begin
         s_d.active  = 1'b0;
         s_d.off_win = 1'b1;
      end
      // a newer write's turn-on wins over an older turn-off
      if (on_t.done) begin
         s_d.active = 1'b1;
         s_d.on_win = 1'b1;
      end
      if (power_down || !set_legal) begin
         s_d.active = 1'b0;
      end

      // per-line switches
      if (power_down) begin
         s_d.dq_en  = '0;
         s_d.dm_en  = '0;
         s_d.dqs_en = '0;
      end else if (self_refresh) begin
         s_d.dq_en  = {DQ_W{cke_s && set_legal}};
         s_d.dm_en  = {DM_W{cke_s && set_legal}};
         s_d.dqs_en = {DQS_W{cke_s && set_legal}};
      end else if (write_leveling) begin
         s_d.dq_en  = '0;
         s_d.dm_en  = '0;
         s_d.dqs_en = {DQS_W{set_legal}};
      end else begin
         s_d.dq_en  = {DQ_W{s_d.active}};
         s_d.dm_en  = {DM_W{s_d.active}};
         s_d.dqs_en = {DQS_W{s_d.active}};
      end

      s_d.strength = (|{s_d.dq_en, s_d.dm_en, s_d.dqs_en}) ? term_setting : TERM_DISABLED;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // outputs, all from flops
   assign dq_term_en           = s_q.dq_en;
   assign dm_term_en           = s_q.dm_en;
   assign dqs_term_en          = s_q.dqs_en;
   assign termination_strength = s_q.strength;
   assign term_on_window       = s_q.on_win;
   assign term_off_window      = s_q.off_win;
   assign term_on_latency      = s_q.on_lat;
   assign term_off_latency     = s_q.off_lat;
   assign lat_undefined        = s_q.lat_undef;

endmodule : dqt_term_ctrl
`default_nettype wire

// >>> tb/dqt_term_ctrl_assertions.sv
// dqt_term_ctrl_assertions: port-level checks of the termination control
// assumes: bound to dqt_term_ctrl, mode bits live on clk
`timescale 1ns/1ps
`default_nettype none
module dqt_term_ctrl_assertions
   import dqt_pkg::*;
#(
   parameter int unsigned DQ_W  = 16,
   parameter int unsigned DM_W  = 2,
   parameter int unsigned DQS_W = 2
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic [SET_W-1:0] term_setting,
   input wire logic             power_down,
   input wire logic             self_refresh,
   input wire logic             write_leveling,
   input wire logic [DQ_W-1:0]  dq_term_en,
   input wire logic [DM_W-1:0]  dm_term_en,
   input wire logic [DQS_W-1:0] dqs_term_en,
   input wire logic [SET_W-1:0] termination_strength,
   input wire logic             term_on_window,
   input wire logic             term_off_window,
   input wire logic             lat_undefined
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic legal;
   logic any_on;
   assign legal  = term_setting inside {[3'h1:3'h6]};
   assign any_on = |{dq_term_en, dm_term_en, dqs_term_en};
   a_pd_all_off: assert property (power_down |=> !any_on)
      else $error("termination on in power-down");
   a_wl_dq_off: assert property (write_leveling && !power_down |=> !(|{dq_term_en, dm_term_en}))
      else $error("data or mask termination on in write leveling");
   a_wl_dqs_state: assert property (write_leveling && !power_down && !self_refresh
      |=> dqs_term_en == {DQS_W{$past(legal)}})
      else $error("strobe termination wrong in write leveling");
   a_sr_disabled: assert property (self_refresh && !legal && !power_down |=> !any_on)
      else $error("termination on in self refresh with setting off");
   a_on_single: assert property (term_on_window |=> !term_on_window)
      else $error("turn-on window pulse longer than one cycle");
   a_on_with_window: assert property ($rose(dq_term_en[0]) && !$past(self_refresh)
      && !$past(write_leveling) |-> term_on_window)
      else $error("termination rose without turn-on window");
   a_off_with_window: assert property (term_off_window && !$past(write_leveling || self_refresh)
      |-> !any_on)
      else $error("termination still on at turn-off window");
   a_strength_follows: assert property (termination_strength
      == (any_on ? $past(term_setting) : 3'h0))
      else $error("termination strength mismatch");
   a_undef_sticky: assert property (lat_undefined |=> lat_undefined)
      else $error("undefined latency flag cleared");
endmodule : dqt_term_ctrl_assertions
bind dqt_term_ctrl dqt_term_ctrl_assertions #(.DQ_W(DQ_W), .DM_W(DM_W), .DQS_W(DQS_W)) chk (
   .clk, .rst, .term_setting, .power_down, .self_refresh, .write_leveling, .dq_term_en,
   .dm_term_en, .dqs_term_en, .termination_strength, .term_on_window, .term_off_window,
   .lat_undefined);
`default_nettype wire

// >>> tb/dqt_ctl_model.sv
// dqt_ctl_model: controller side, free-running link clock and command pins
// assumes: commands change at link falling edges, idle command pins low, CKE idles high
`timescale 1ns/1ps
`default_nettype none
module dqt_ctl_model (
   output var logic link_ck,
   output var logic cke,
   output var logic cmd_write1,
   output var logic cmd_mask_write1,
   output var logic cmd_mpc_wr_fifo,
   output var logic cmd_cas2,
   output var logic cmd_bl32,
   output var int   rises
);
   initial begin
      {cke, cmd_write1, cmd_mask_write1, cmd_mpc_wr_fifo, cmd_cas2, cmd_bl32} = 6'h20;
      link_ck = 1'b0;
      #137;
      forever #200 link_ck = ~link_ck;
   end
   // link rises counted from the cas-2 edge
   always @(posedge link_ck) rises <= cmd_cas2 ? 0 : rises + 1;
   task automatic issue(input int kind, input logic bl32);
      @(negedge link_ck);
      cmd_write1 = (kind == 0);
      cmd_mask_write1 = (kind == 1);
      cmd_mpc_wr_fifo = (kind == 2);
      cmd_bl32 = bl32;
      @(negedge link_ck);
      {cmd_write1, cmd_mask_write1, cmd_mpc_wr_fifo, cmd_bl32} = 4'h0;
      cmd_cas2 = 1'b1;
      @(negedge link_ck);
      cmd_cas2 = 1'b0;
   endtask : issue
   task automatic set_cke(input logic v);
      cke = v;
   endtask : set_cke
endmodule : dqt_ctl_model
`default_nettype wire

// >>> tb/dqt_term_ctrl_tb.sv
// dqt_term_ctrl_tb: self-checking bench for the termination control
// assumes: 20 MHz core clock, controller model makes the 400 ns link clock
`timescale 1ns/1ps
`default_nettype none
module dqt_term_ctrl_tb;
   import dqt_pkg::*;
   logic        clk = 1'b0;
   logic        rst, link_ck, cke, cmd_write1, cmd_mask_write1, cmd_mpc_wr_fifo;
   logic        cmd_cas2, cmd_bl32, write_latency_set_b, wr_preamble_2ck;
   logic        power_down, self_refresh, write_leveling, term_on_window, term_off_window;
   logic        lat_undefined;
   logic [2:0]  term_setting, termination_strength;
   logic [5:0]  term_on_latency, term_off_latency;
   logic [15:0] dq_term_en;
   logic [1:0]  dm_term_en, dqs_term_en;
   logic [19:0] all_en;
   dqt_bin_t    freq_bin;
   int          mismatches = 0;
   int          n_checks = 0;
   assign all_en = {dq_term_en, dm_term_en, dqs_term_en};
   dqt_ctl_model ctl (.link_ck, .cke, .cmd_write1, .cmd_mask_write1, .cmd_mpc_wr_fifo,
      .cmd_cas2, .cmd_bl32, .rises());
   dqt_term_ctrl dut (.clk, .rst, .link_ck, .cke, .cmd_write1, .cmd_mask_write1,
      .cmd_mpc_wr_fifo, .cmd_cas2, .cmd_bl32, .term_setting, .freq_bin, .write_latency_set_b,
      .wr_preamble_2ck, .power_down, .self_refresh, .write_leveling, .dq_term_en, .dm_term_en,
      .dqs_term_en, .termination_strength, .term_on_window, .term_off_window,
      .term_on_latency, .term_off_latency, .lat_undefined);
   initial begin
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (exp !== got) begin
         mismatches++;
         $display("ERROR %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   task automatic wait_win(input bit off);
      int i;
      for (i = 0; i < 800; i++) begin
         @(negedge clk);
         if ((off ? term_off_window : term_on_window) === 1'b1) break;
      end
      check("window seen", 1, i < 800);
   endtask : wait_win
   task automatic quiet(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(negedge clk);
         seen = seen | (|all_en);
      end
      check("termination stayed off", 0, seen);
   endtask : quiet
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_write(input int kind, input logic bl32, input int on, input int off);
      ctl.issue(kind, bl32);
      wait_win(1'b0);
      check("on latency", on, ctl.rises);
      check("on latency port", on, term_on_latency);
      check("off latency port", off, term_off_latency);
      check("all lines on", 20'hfffff, all_en);
      check("strength", term_setting, termination_strength);
      wait_win(1'b1);
      check("off latency", off, ctl.rises);
      check("all lines off", 0, all_en);
   endtask : t_write
   task automatic t_bins();
      int lat [6][4] = '{'{0, 6, 0, 22}, '{4, 12, 20, 28}, '{4, 14, 22, 32},
                         '{6, 18, 24, 36}, '{6, 20, 26, 40}, '{8, 24, 28, 44}};
      int k = 0;
      for (int b = 2; b < 8; b++) begin
         for (int s = 0; s < 2; s++) begin
            if (b > 2 || s == 1) begin
               freq_bin = dqt_bin_t'(b);
               write_latency_set_b = s[0];
               term_setting = 3'(k % 6 + 1);
               t_write(k % 3, k[0], lat[b-2][s], lat[b-2][s+2] + 8 * k[0]);
               k++;
            end
         end
      end
   endtask : t_bins
   task automatic t_disabled();
      for (int i = 0; i < 2; i++) begin
         term_setting = i ? 3'h7 : 3'h0;
         ctl.issue(i, 1'b0);
         quiet(450);
      end
   endtask : t_disabled
   task automatic t_powerdown();
      term_setting = 3'h2;
      ctl.issue(0, 1'b0);
      wait_win(1'b0);
      power_down = 1'b1;
      repeat (2) @(negedge clk);
      quiet(450);
      power_down = 1'b0;
   endtask : t_powerdown
   task automatic t_selfref();
      self_refresh = 1'b1;
      term_setting = 3'h5;
      ctl.set_cke(1'b0);
      repeat (6) @(negedge clk);
      check("self refresh cke low", 0, all_en);
      ctl.set_cke(1'b1);
      repeat (6) @(negedge clk);
      check("self refresh cke high", 20'hfffff, all_en);
      term_setting = 3'h0;
      repeat (2) @(negedge clk);
      check("self refresh disabled", 0, all_en);
      self_refresh = 1'b0;
   endtask : t_selfref
   task automatic t_wlevel();
      write_leveling = 1'b1;
      for (int i = 0; i < 2; i++) begin
         term_setting = i ? 3'h4 : 3'h0;
         repeat (3) @(negedge clk);
         check("leveling strobes", {2{i[0]}}, dqs_term_en);
         check("leveling data mask", 0, all_en[19:2]);
      end
      write_leveling = 1'b0;
   endtask : t_wlevel
   task automatic t_preamble();
      term_setting = 3'h3;
      wr_preamble_2ck = 1'b0;
      check("flag clear", 0, lat_undefined);
      ctl.issue(1, 1'b0);
      quiet(450);
      check("flag set", 1, lat_undefined);
      // mid-run reset clears the sticky flag, then an undefined bin sets it again
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      check("flag cleared by reset", 0, lat_undefined);
      check("lines off after reset", 0, all_en);
      wr_preamble_2ck = 1'b1;
      freq_bin = BIN_266_533;
      repeat (4) @(negedge clk);
      ctl.issue(2, 1'b0);
      quiet(450);
      check("flag set undefined bin", 1, lat_undefined);
   endtask : t_preamble
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      term_setting = 3'h0;
      freq_bin = BIN_1866_2133;
      write_latency_set_b = 1'b0;
      wr_preamble_2ck = 1'b1;
      power_down = 1'b0;
      self_refresh = 1'b0;
      write_leveling = 1'b0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      t_bins();
      t_disabled();
      t_powerdown();
      t_selfref();
      t_wlevel();
      t_preamble();
      print_verdict();
   end
   initial begin
      #1_000_000;
      mismatches++;
      $display("ERROR watchdog expected end seen hang");
      print_verdict();
   end
endmodule : dqt_term_ctrl_tb
`default_nettype wire
